// ---- uart_status_cfg.svh ----
// Constants for the line and modem status block: offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef UART_STATUS_CFG_SVH
`define UART_STATUS_CFG_SVH
// Register offsets on the plain register port
`define OFF_LINE_STATUS 3'h0
`define OFF_MODEM_STATUS 3'h1
`define OFF_MODEM_CONTROL 3'h2
`define OFF_IRQ_STATUS 3'h3
`define OFF_IRQ_MASK 3'h4
// Line status field positions
`define LS_DATA_READY 0
`define LS_OVERRUN 1
`define LS_PARITY 2
`define LS_FIFO_ERROR 7
// Modem status field positions
`define MS_DCTS 0
`define MS_DDSR 1
`define MS_TERI 2
`define MS_DDCD 3
// Modem control field positions
`define MC_DTR 0
`define MC_RTS 1
`define MC_OUT1 2
`define MC_OUT2 3
`define MC_LOOP 4
// Interrupt status field positions
`define IS_MODEM 0
`define IS_OVERRUN 1
`define IS_PARITY 2
// Reset values
`define RST_MODEM_CONTROL 8'h00
`define RST_IRQ_MASK 8'h00
`define RST_DELTA 4'h0
`endif

// ---- uart_status_pkg.sv ----
// Types shared by the status block and its receive queue.
// Assumes the constants header sits in the same folder.
`include "uart_status_cfg.svh"
package uart_status_pkg;
	// One received character with its error marks
	typedef struct packed {
		logic brk;
		logic frame_err;
		logic parity_err;
		logic [7:0] data;
	} rx_char_t;
	// Modem inputs as true (active-high) levels
	typedef struct packed {
		logic dcd;
		logic ri;
		logic dsr;
		logic cts;
	} modem_lines_t;
endpackage

// ---- rx_queue.sv ----
// Small receive FIFO holding characters with their error marks.
// Assumes push is never asserted while full; read data are registered.
module rx_queue #(
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic push,
	input uart_status_pkg::rx_char_t push_data,
	input wire logic pop,
	output uart_status_pkg::rx_char_t head_r,
	output logic [AW:0] count_r,
	output logic err_any
);
	import uart_status_pkg::*;

	rx_char_t mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic do_push;
	logic do_pop;

	assign do_push = push && (count_r != (AW+1)'(DEPTH));
	assign do_pop = pop && (count_r != '0);

	// Storage; the head is re-read every cycle so it tracks pops
	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem[wr_ptr_r] <= push_data;
		end
		// Push into an empty queue bypasses memory, else the head lags a cycle
		if (do_push && count_r == (AW+1)'(do_pop)) begin
			head_r <= push_data;
		end else begin
			head_r <= mem[do_pop ? rd_ptr_r + 1'b1 : rd_ptr_r];
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (do_push) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (do_pop) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end

	// Any stored character still marked bad
	always_comb begin
		err_any = 1'b0;
		for (int i = 0; i < DEPTH; i++) begin
			if (AW'(i - int'(rd_ptr_r)) < count_r[AW-1:0] || (count_r[AW] && 1'b1)) begin
				if (mem[i].parity_err || mem[i].frame_err || mem[i].brk) begin
					err_any = 1'b1;
				end
			end
		end
	end
endmodule

// ---- uart_line_modem_status.sv ----
// Line status bits 0 to 2 and 7 and modem status register of one UART channel.
// Assumes the receiver delivers a complete character as a one-cycle pulse, and that
// modem inputs are synchronous to clk_sys but still pass a two-stage stage for safety.
//
// Local design decisions: strobed register access and the address map.
`include "uart_status_cfg.svh"

module uart_line_modem_status #(
	parameter int FIFO_DEPTH = 16,
	parameter int FIFO_AW = 4
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic fifo_en,
	input wire logic rx_done,
	input uart_status_pkg::rx_char_t rx_char,
	input wire logic rx_pop,
	output uart_status_pkg::rx_char_t rx_head,
	input wire logic carrier_n,
	input wire logic ring_n,
	input wire logic dsr_n,
	input wire logic cts_n,
	output logic modem_irq,
	output logic irq
);
	import uart_status_pkg::*;

	// ********************************
	// Receive path
	// ********************************
	rx_char_t hold_r;
	logic hold_full_r;
	logic overrun_r;
	rx_char_t q_head;
	logic [FIFO_AW:0] q_count;
	logic q_err;
	logic q_full;
	logic q_push;
	logic rd_line;
	logic rd_modem;
	logic overrun_evt;

	assign rd_line = reg_rd && (reg_addr == `OFF_LINE_STATUS);
	assign rd_modem = reg_rd && (reg_addr == `OFF_MODEM_STATUS);
	assign q_full = (q_count == (FIFO_AW+1)'(FIFO_DEPTH));
	assign q_push = fifo_en && rx_done && !q_full;
	// Character arrives with no room: full queue, or unread holding register
	assign overrun_evt = rx_done && ((fifo_en && q_full) || (!fifo_en && hold_full_r && !rx_pop));

	rx_queue #(
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_queue (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.push(q_push),
		.push_data(rx_char),
		.pop(fifo_en && rx_pop),
		.head_r(q_head),
		.count_r(q_count),
		.err_any(q_err)
	);

	// Non-FIFO holding register; a new character simply replaces the old one
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			hold_r <= '0;
			hold_full_r <= 1'b0;
		end else if (!fifo_en && rx_done) begin
			hold_r <= rx_char;
			hold_full_r <= 1'b1;
		end else if (!fifo_en && rx_pop) begin
			hold_full_r <= 1'b0;
		end
	end

	// Overrun: the full FIFO keeps its contents, the new character is lost; set beats read clear
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			overrun_r <= 1'b0;
		end else if (overrun_evt) begin
			overrun_r <= 1'b1;
		end else if (rd_line) begin
			overrun_r <= 1'b0;
		end
	end

	// Head character seen by software
	always_comb begin
		rx_head = fifo_en ? q_head : hold_r;
	end

	// ********************************
	// Line status
	// ********************************
	logic [7:0] line_status;
	always_comb begin
		line_status = 8'h00;
		line_status[`LS_DATA_READY] = fifo_en ? (q_count != '0) : hold_full_r;
		line_status[`LS_OVERRUN] = overrun_r;
		line_status[`LS_PARITY] = line_status[`LS_DATA_READY] && rx_head.parity_err;
		line_status[`LS_FIFO_ERROR] = fifo_en && q_err;
	end

	// ********************************
	// Modem control and status
	// ********************************
	logic [7:0] modem_control_r;
	logic loopback;
	modem_lines_t pin_s1_r;
	modem_lines_t pin_s2_r;
	modem_lines_t lines;
	modem_lines_t lines_prev_r;
	logic prev_valid_r;
	logic [3:0] delta_r;
	logic [3:0] delta_set;

	assign loopback = modem_control_r[`MC_LOOP];

	// Register file writes to modem control
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			modem_control_r <= `RST_MODEM_CONTROL;
		end else if (reg_wr && reg_addr == `OFF_MODEM_CONTROL) begin
			modem_control_r <= reg_wdata;
		end
	end

	// Two-stage synchroniser; stage one feeds only stage two
	always_ff @(posedge clk_sys) begin
		pin_s1_r <= {~carrier_n, ~ring_n, ~dsr_n, ~cts_n};
		pin_s2_r <= pin_s1_r;
	end

	// Pin levels or loopback sources
	always_comb begin
		if (loopback) begin
			lines.dcd = modem_control_r[`MC_OUT2];
			lines.ri = modem_control_r[`MC_OUT1];
			lines.dsr = modem_control_r[`MC_DTR];
			lines.cts = modem_control_r[`MC_RTS];
		end else begin
			lines = pin_s2_r;
		end
	end

	// Edge detect; first valid sample after reset only primes the history
	always_comb begin
		delta_set = 4'h0;
		if (prev_valid_r) begin
			delta_set[`MS_DCTS] = lines.cts ^ lines_prev_r.cts;
			delta_set[`MS_DDSR] = lines.dsr ^ lines_prev_r.dsr;
			delta_set[`MS_DDCD] = lines.dcd ^ lines_prev_r.dcd;
			delta_set[`MS_TERI] = lines_prev_r.ri && !lines.ri;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			lines_prev_r <= '0;
			prev_valid_r <= 1'b0;
		end else begin
			lines_prev_r <= lines;
			prev_valid_r <= 1'b1;
		end
	end

	// Change bits: a change in the read cycle survives the clear
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			delta_r <= `RST_DELTA;
		end else if (rd_modem) begin
			delta_r <= delta_set;
		end else begin
			delta_r <= delta_r | delta_set;
		end
	end

	assign modem_irq = |delta_r;

	// ********************************
	// Interrupt status and mask
	// ********************************
	logic [7:0] irq_status_r;
	logic [7:0] irq_mask_r;
	logic [7:0] irq_events;

	always_comb begin
		irq_events = 8'h00;
		irq_events[`IS_MODEM] = |delta_set;
		irq_events[`IS_OVERRUN] = overrun_evt;
		irq_events[`IS_PARITY] = rx_done && rx_char.parity_err;
	end

	// Sticky bits, write one to clear, new event wins
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			irq_status_r <= 8'h00;
		end else if (reg_wr && reg_addr == `OFF_IRQ_STATUS) begin
			irq_status_r <= (irq_status_r & ~reg_wdata) | irq_events;
		end else begin
			irq_status_r <= irq_status_r | irq_events;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			irq_mask_r <= `RST_IRQ_MASK;
		end else if (reg_wr && reg_addr == `OFF_IRQ_MASK) begin
			irq_mask_r <= reg_wdata;
		end
	end

	assign irq = |(irq_status_r & irq_mask_r);

	// ********************************
	// Read port, data one cycle after the strobe
	// ********************************
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`OFF_LINE_STATUS: reg_rdata <= line_status;
				`OFF_MODEM_STATUS: reg_rdata <= {lines.dcd, lines.ri, lines.dsr, lines.cts, delta_r};
				`OFF_MODEM_CONTROL: reg_rdata <= modem_control_r;
				`OFF_IRQ_STATUS: reg_rdata <= irq_status_r;
				`OFF_IRQ_MASK: reg_rdata <= irq_mask_r;
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end
endmodule

// ---- uart_line_modem_status_chk.sv ----
// Checker for the line and modem status block.
// Assumes it is bound to the block and sees its ports only.
module uart_line_modem_status_chk
	import uart_status_pkg::*;
#(
	parameter int FIFO_DEPTH = 16,
	parameter int FIFO_AW = 4
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic fifo_en,
	input wire logic rx_done,
	input rx_char_t rx_char,
	input wire logic rx_pop,
	input rx_char_t rx_head,
	input wire logic carrier_n,
	input wire logic ring_n,
	input wire logic dsr_n,
	input wire logic cts_n,
	input wire logic modem_irq,
	input wire logic irq
);
	// ****************
	// Helper state
	// ****************
	logic [4:0] mc_r;
	logic [1:0] q_r;
	logic [3:0] pin_q;
	logic ms_rd;
	logic pins_still;
	assign ms_rd = reg_rd && reg_addr == 3'h1;
	// Pins unchanged since the last edge, so no edge is still in flight
	assign pins_still = (pin_q == {carrier_n, ring_n, dsr_n, cts_n});
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// Mirror of control writes; quiet count guards the sync delay
	always_ff @(posedge clk_sys) begin
		pin_q <= {carrier_n, ring_n, dsr_n, cts_n};
		if (!resetn) begin
			mc_r <= 5'h00;
			q_r <= 2'h0;
		end else begin
			if (reg_wr && reg_addr == 3'h2) mc_r <= reg_wdata[4:0];
			if ((reg_wr && reg_addr == 3'h2) || pin_q != {carrier_n, ring_n, dsr_n, cts_n}) q_r <= 2'h0;
			else if (q_r != 2'h3) q_r <= q_r + 2'h1;
		end
	end
	parity_head_a: assert property (reg_rd && reg_addr == 3'h0
		|=> reg_rdata[2] == ($past(rx_head.parity_err) && reg_rdata[0])) else $error("parity flag off head");
	fifo_err_a: assert property (reg_rd && reg_addr == 3'h0 && fifo_en
		|=> !reg_rdata[2] || reg_rdata[7]) else $error("fifo error flag missing");
	pin_level_a: assert property (ms_rd && q_r == 2'h3 && pins_still && !mc_r[4]
		|=> reg_rdata[7:4] == ~$past({carrier_n, ring_n, dsr_n, cts_n})) else $error("modem level wrong");
	loop_level_a: assert property (ms_rd && q_r == 2'h3 && mc_r[4]
		|=> reg_rdata[7:4] == $past({mc_r[3], mc_r[2], mc_r[0], mc_r[1]})) else $error("loopback level wrong");
	pin_delta_a: assert property (($changed({carrier_n, dsr_n, cts_n}) || $rose(ring_n)) && !mc_r[4]
		|-> ##[1:5] modem_irq) else $error("change bit not latched");
	ms_irq_a: assert property (ms_rd |=> (reg_rdata[3:0] != 4'h0) == $past(modem_irq)) else $error("irq vs delta");
	irq_fall_a: assert property ($fell(modem_irq) |-> $past(ms_rd)) else $error("modem irq fell unread");
	int_drop_a: assert property ($fell(irq)
		|-> $past(reg_wr) && $past(reg_addr) inside {3'h3, 3'h4}) else $error("irq fell unasked");
	// Main scenarios reached
	cover property (ms_rd && mc_r[4]);
	cover property ($rose(modem_irq));
	cover property ($rose(irq));
endmodule

bind uart_line_modem_status uart_line_modem_status_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) u_chk (
	.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .fifo_en(fifo_en), .rx_done(rx_done), .rx_char(rx_char),
	.rx_pop(rx_pop), .rx_head(rx_head), .carrier_n(carrier_n), .ring_n(ring_n), .dsr_n(dsr_n),
	.cts_n(cts_n), .modem_irq(modem_irq), .irq(irq));

// ---- modem_peer.sv ----
// Modem side model driving the four active-low modem pins.
// Assumes the bench asks for true levels right after a clock edge.
module modem_peer (
	input wire logic clk_sys,
	input uart_status_pkg::modem_lines_t want,
	output logic carrier_n,
	output logic ring_n,
	output logic dsr_n,
	output logic cts_n
);
	import uart_status_pkg::*;
	// Pins follow one cycle late, like a slow modem; idle high
	always_ff @(posedge clk_sys) begin
		{carrier_n, ring_n, dsr_n, cts_n} <= ~want;
	end
endmodule

// ---- uart_line_modem_status_tb_top.sv ----
// Bench for the line and modem status block with a modem peer.
// Assumes a 50 MHz clock and a four-entry receive queue.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module uart_line_modem_status_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import uart_status_pkg::*;
	// ****************
	// Stimulus and tests
	// ****************
	logic clk_sys = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic fifo_en = 1'b0, rx_done = 1'b0, rx_pop = 1'b0;
	logic carrier_n, ring_n, dsr_n, cts_n, modem_irq, irq;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
	rx_char_t rx_char = '0, rx_head;
	modem_lines_t want = '0;
	int num_errors = 0, comparisons = 0;
	always #10 clk_sys = ~clk_sys;
	modem_peer u_peer (.clk_sys(clk_sys), .want(want), .carrier_n(carrier_n), .ring_n(ring_n),
		.dsr_n(dsr_n), .cts_n(cts_n));
	uart_line_modem_status #(.FIFO_DEPTH(4), .FIFO_AW(2)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.fifo_en(fifo_en), .rx_done(rx_done), .rx_char(rx_char), .rx_pop(rx_pop), .rx_head(rx_head),
		.carrier_n(carrier_n), .ring_n(ring_n), .dsr_n(dsr_n), .cts_n(cts_n), .modem_irq(modem_irq), .irq(irq));
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_sys) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
		@(posedge clk_sys) reg_wr <= 1'b0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk_sys) {reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk_sys) reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task push(input logic pe, input logic [7:0] v);
		@(posedge clk_sys) {rx_done, rx_char} <= {1'b1, 2'b00, pe, v};
		@(posedge clk_sys) rx_done <= 1'b0;
	endtask
	task pop;
		@(posedge clk_sys) rx_pop <= 1'b1;
		@(posedge clk_sys) rx_pop <= 1'b0;
		#1;
	endtask
	task pin(input int i, input logic v);
		@(posedge clk_sys) want[i] <= v;
		cyc(8);
	endtask
	task t_pins;
		for (int i = 0; i < 4; i++) begin
			pin(i, 1'b1);
			`CHK(irq, 1'(i != 2))
			`CHK(modem_irq, 1'(i != 2))
			rd(3'h1, d);
			`CHK(d, {4'(1 << i), (i == 2) ? 4'h0 : 4'(1 << i)})
			rd(3'h1, d);
			`CHK(d[3:0], 4'h0)
			`CHK(modem_irq, 1'b0)
			wr(3'h3, 8'h07);
			`CHK(irq, 1'b0)
			pin(i, 1'b0);
			rd(3'h1, d);
			`CHK(d, {4'h0, 4'(1 << i)})
			wr(3'h3, 8'h07);
		end
	endtask
	task t_loop;
		wr(3'h2, 8'h15);
		cyc(4);
		rd(3'h1, d);
		`CHK(d[7:4], 4'h6)
		wr(3'h2, 8'h1A);
		cyc(4);
		rd(3'h1, d);
		`CHK(d[7:4], 4'h9)
		wr(3'h2, 8'h00);
		cyc(4);
		rd(3'h1, d);
		`CHK(d[7:4], 4'h0)
		wr(3'h3, 8'h07);
	endtask
	// Single register first, then a full queue refusing a fifth character
	task t_rx;
		push(1'b1, 8'hA5);
		push(1'b0, 8'h3C);
		rd(3'h0, d);
		`CHK(d[2:0], 3'h3)
		`CHK(rx_head.data, 8'h3C)
		rd(3'h3, d);
		`CHK(d, 8'h06)
		pop();
		rd(3'h0, d);
		`CHK(d[2:0], 3'h0)
		@(posedge clk_sys) fifo_en <= 1'b1;
		for (int i = 1; i < 6; i++) push(1'(i == 1), 8'(8'h11 * i));
		rd(3'h0, d);
		`CHK(d & 8'h87, 8'h87)
		for (int i = 1; i < 5; i++) begin
			if (i == 2) begin
				rd(3'h0, d);
				`CHK(d & 8'h87, 8'h01)
			end
			`CHK(rx_head.data, 8'(8'h11 * i))
			pop();
		end
		rd(3'h0, d);
		`CHK(d & 8'h87, 8'h00)
		push(1'b0, 8'h66);
		#1 `CHK(rx_head.data, 8'h66)
	endtask
	task close_out;
		if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Watchdog well beyond the roughly 200 cycles the tests need
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(3'h1, d);
		`CHK(d, 8'h00)
		wr(3'h7, 8'hFF);
		rd(3'h7, d);
		`CHK(d, 8'h00)
		wr(3'h4, 8'h07);
		t_pins();
		t_loop();
		t_rx();
		close_out();
	end
endmodule
